// [rtl/lgp_consts.svh]
`ifndef LGP_CONSTS_SVH
`define LGP_CONSTS_SVH

// ========================================
// register indices (byte address = 4 * index)
`define LGP_IDX_STATN      6'h13
`define LGP_IDX_GPIO       6'h14
`define LGP_IDX_PACE       6'h15
`define LGP_IDX_INT_STAT   6'h18
`define LGP_IDX_INT_MASK   6'h19
`define LGP_IDX_SENSE      6'h1a
`define LGP_IDX_RESP       6'h1b

// ========================================
// field positions
`define LGP_GPIO_DAT_MSB   7
`define LGP_GPIO_DAT_LSB   4
`define LGP_GPIO_DIR_MSB   3
`define LGP_GPIO_DIR_LSB   0
`define LGP_PACE_EVEN_MSB  4
`define LGP_PACE_EVEN_LSB  3
`define LGP_PACE_ODD_MSB   2
`define LGP_PACE_ODD_LSB   1
`define LGP_PACE_BUF_BIT   0

// ========================================
// reset values
`define LGP_STATN_RST      8'h00
`define LGP_GPIO_DAT_RST   4'h0
`define LGP_GPIO_DIR_RST   4'hf
`define LGP_PACE_RST       8'h00
`define LGP_PACE_EVEN_RST  2'h0
`define LGP_PACE_ODD_RST   2'h0
`define LGP_PACE_BUF_RST   1'h0
`define LGP_PACE_HOT_RST   4'h1
`define LGP_SENSE_RST      8'h00
`define LGP_MASK_RST       8'h00

`endif

// [rtl/lgp_pkg.sv]
package lgp_pkg;

    // respiration modes
    typedef enum logic [1:0] {
        LGP_RESP_NONE     = 2'b00,
        LGP_RESP_EXTERNAL = 2'b01,
        LGP_RESP_INT_INT  = 2'b10,
        LGP_RESP_INT_USER = 2'b11
    } lgp_resp_t;

    // whole state of the register bank
    typedef struct packed {
        logic            ack;
        logic [7:0]      dat;
        logic [7:0]      loff_s1;
        logic [7:0]      loff_s2;
        logic [7:0]      loff_prev;
        logic [3:0]      gpio_s1;
        logic [3:0]      gpio_s2;
        logic [3:0]      gpio_dat;
        logic [3:0]      gpio_dir;
        logic [3:0]      gpio_oe;
        logic [3:0]      gpio_out;
        logic [1:0]      pace_even;
        logic [1:0]      pace_odd;
        logic            pace_buf;
        logic [3:0]      even_hot;
        logic [3:0]      odd_hot;
        logic [7:0]      sense_en;
        lgp_resp_t       resp_mode;
        logic [7:0]      int_st;
        logic [7:0]      int_mask;
        logic            irq;
    } lgp_state_t;

endpackage

// [rtl/lgp_regs.sv]
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`include "lgp_consts.svh"

module lgp_regs #(
    parameter int NUM_CH = 8,
    parameter int ADR_W  = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // lead-off comparators and sensing
    input  wire logic [7:0]       chan_neg_electrode_off_i,
    output logic      [7:0]       negative_sense_enable_o,
    output logic      [1:0]       respiration_mode_o,
    // general-purpose pins
    input  wire logic [3:0]       gpio_in_i,
    output logic      [3:0]       gpio_out_o,
    output logic      [3:0]       gpio_oe_o,
    // pace routing
    output logic      [3:0]       pace_test_output_one_sel_o,
    output logic      [3:0]       pace_test_output_two_sel_o,
    output logic                  pace_buffer_enable_o,
    // interrupt
    output logic                  irq_o
);

    // ========================================
    // state and reset value
    lgp_pkg::lgp_state_t st_r;
    lgp_pkg::lgp_state_t st_nxt;

    localparam lgp_pkg::lgp_state_t ST_RST = '{
        gpio_dat  : `LGP_GPIO_DAT_RST,
        gpio_dir  : `LGP_GPIO_DIR_RST,
        pace_even : `LGP_PACE_EVEN_RST,
        pace_odd  : `LGP_PACE_ODD_RST,
        pace_buf  : `LGP_PACE_BUF_RST,
        even_hot  : `LGP_PACE_HOT_RST,
        odd_hot   : `LGP_PACE_HOT_RST,
        sense_en  : `LGP_SENSE_RST,
        int_mask  : `LGP_MASK_RST,
        resp_mode : lgp_pkg::LGP_RESP_NONE,
        loff_s2   : `LGP_STATN_RST,
        default   : '0
    };

    // ========================================
    // channel presence per variant
    logic [3:0] even_ok;
    logic [3:0] odd_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_present
            assign even_ok[gi] = (2 * gi + 2) <= NUM_CH;
            assign odd_ok[gi]  = (2 * gi + 1) <= NUM_CH;
        end
    endgenerate

    // ========================================
    // bus decode
    logic [5:0] idx;
    logic       hit;
    logic       wr;
    logic       rd;

    assign idx = wb_adr_i[7:2];
    assign hit = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign wr  = hit & wb_we_i & wb_sel_i[0];
    assign rd  = hit & ~wb_we_i;

    // ========================================
    // next state
    logic [3:0] avail_cur;
    logic [3:0] avail_nxt;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;

    always_comb begin
        st_nxt = st_r;
        // pin synchronisers
        st_nxt.loff_s1   = chan_neg_electrode_off_i;
        st_nxt.loff_s2   = st_r.loff_s1;
        st_nxt.loff_prev = st_r.loff_s2;
        st_nxt.gpio_s1   = gpio_in_i;
        st_nxt.gpio_s2   = st_r.gpio_s1;

        // modes 01 and 11 take pins 2-4
        avail_cur = st_r.resp_mode[0] ? 4'h1 : 4'hf;

        // bus answer one cycle after the request
        st_nxt.ack = hit;
        st_nxt.dat = 8'h00;
        if (rd) begin
            case (idx)
                `LGP_IDX_STATN:    st_nxt.dat = st_r.loff_s2;
                `LGP_IDX_GPIO:     st_nxt.dat = {st_r.gpio_s2 & avail_cur,
                                                 st_r.gpio_dir};
                `LGP_IDX_PACE:     st_nxt.dat = {3'h0, st_r.pace_even,
                                                 st_r.pace_odd,
                                                 st_r.pace_buf};
                `LGP_IDX_INT_STAT: st_nxt.dat = st_r.int_st;
                `LGP_IDX_INT_MASK: st_nxt.dat = st_r.int_mask;
                `LGP_IDX_SENSE:    st_nxt.dat = st_r.sense_en;
                `LGP_IDX_RESP:     st_nxt.dat = {6'h00, st_r.resp_mode};
                default:           st_nxt.dat = 8'h00;
            endcase
        end

        // register writes; the status index takes none
        if (wr) begin
            case (idx)
                `LGP_IDX_GPIO: begin
                    st_nxt.gpio_dat = (wb_dat_i[7:4] & ~st_r.gpio_dir)
                                    | (st_r.gpio_dat & st_r.gpio_dir);
                    st_nxt.gpio_dir = wb_dat_i[3:0];
                end
                `LGP_IDX_PACE: begin
                    st_nxt.pace_even = wb_dat_i[4:3];
                    st_nxt.pace_odd  = wb_dat_i[2:1];
                    st_nxt.pace_buf  = wb_dat_i[0];
                end
                `LGP_IDX_INT_MASK: st_nxt.int_mask = wb_dat_i[7:0];
                `LGP_IDX_SENSE:    st_nxt.sense_en = wb_dat_i[7:0];
                `LGP_IDX_RESP:     st_nxt.resp_mode =
                                       lgp_pkg::lgp_resp_t'(wb_dat_i[1:0]);
                default:           st_nxt.ack = hit;
            endcase
        end

        // pin drive follows the new direction and mode
        avail_nxt = st_nxt.resp_mode[0] ? 4'h1 : 4'hf;
        st_nxt.gpio_oe  = ~st_nxt.gpio_dir & avail_nxt;
        st_nxt.gpio_out = st_nxt.gpio_dat & st_nxt.gpio_oe;

        // one-hot pace routing, absent channels never selected
        st_nxt.even_hot = (4'h1 << st_nxt.pace_even) & even_ok;
        st_nxt.odd_hot  = (4'h1 << st_nxt.pace_odd) & odd_ok;

        // electrode-off events on sensed channels, set beats read clear
        ev_set = st_r.loff_s2 & ~st_r.loff_prev & st_r.sense_en;
        ev_clr = (rd && idx == `LGP_IDX_INT_STAT) ? 8'hff : 8'h00;
        st_nxt.int_st = (st_r.int_st & ~ev_clr) | ev_set;
        st_nxt.irq    = |(st_nxt.int_st & st_nxt.int_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // outputs
    assign wb_dat_o                   = {24'h000000, st_r.dat};
    assign wb_ack_o                   = st_r.ack;
    assign negative_sense_enable_o    = st_r.sense_en;
    assign respiration_mode_o         = st_r.resp_mode;
    assign gpio_out_o                 = st_r.gpio_out;
    assign gpio_oe_o                  = st_r.gpio_oe;
    assign pace_test_output_one_sel_o = st_r.even_hot;
    assign pace_test_output_two_sel_o = st_r.odd_hot;
    assign pace_buffer_enable_o       = st_r.pace_buf;
    assign irq_o                      = st_r.irq;

    // ========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_statn;
        rd && idx == `LGP_IDX_STATN;
    endsequence

    sequence s_rd_gpio;
        rd && idx == `LGP_IDX_GPIO && !st_r.resp_mode[0];
    endsequence

    sequence s_rd_pace;
        rd && idx == `LGP_IDX_PACE;
    endsequence

    sequence s_wr_statn;
        wr && idx == `LGP_IDX_STATN;
    endsequence

    sequence s_wr_pace;
        wr && idx == `LGP_IDX_PACE;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_statn_follows_pin;
        s_rd_statn |=> wb_dat_o[7:0] == $past(chan_neg_electrode_off_i, 3);
    endproperty

    property p_ack_once;
        hit |=> s_ack_pulse;
    endproperty

    AST_STATN_READ: assert property (p_statn_follows_pin)
        else $error("status read does not match synchronised comparators");

    AST_ACK_PULSE: assert property (p_ack_once)
        else $error("ack is not a single cycle after the request");

    AST_STATN_RO: assert property (
        s_wr_statn |=> $stable(gpio_oe_o) && $stable(pace_buffer_enable_o)
                       && $stable(negative_sense_enable_o))
        else $error("write to status index changed other state");

    AST_GPIO_READ: assert property (
        s_rd_gpio |=> wb_dat_o[7:4] == $past(gpio_in_i, 3))
        else $error("pin data read is not the pin level");

    AST_GPIO_RESP_LOSS: assert property (
        respiration_mode_o[0] |-> gpio_oe_o[3:1] == 3'h0)
        else $error("pins 2-4 driven in respiration mode 01 or 11");

    AST_GPIO_DIR: assert property (
        !respiration_mode_o[0] |-> gpio_oe_o == ~st_r.gpio_dir)
        else $error("pin drive does not follow direction field");

    AST_GPIO_RESET: assert property (
        $fell(rst_i) |-> gpio_oe_o == 4'h0 && st_r.gpio_dir == 4'hf)
        else $error("pins not all inputs after reset");

    AST_GPIO_INPUT_KEEP: assert property (
        wr && idx == `LGP_IDX_GPIO |=>
            (st_r.gpio_dat & $past(st_r.gpio_dir))
            == ($past(st_r.gpio_dat) & $past(st_r.gpio_dir)))
        else $error("data write changed an input pin");

    AST_PACE_RSVD: assert property (
        s_rd_pace |=> wb_dat_o[7:5] == 3'h0)
        else $error("reserved pace bits read nonzero");

    AST_PACE_EVEN: assert property (
        s_wr_pace |=> $onehot0(pace_test_output_one_sel_o)
            && pace_test_output_one_sel_o[$past(wb_dat_i[4:3])]
               == even_ok[$past(wb_dat_i[4:3])])
        else $error("even pace routing wrong");

    AST_PACE_ODD: assert property (
        s_wr_pace |=> $onehot0(pace_test_output_two_sel_o)
            && pace_test_output_two_sel_o[$past(wb_dat_i[2:1])]
               == odd_ok[$past(wb_dat_i[2:1])])
        else $error("odd pace routing wrong");

    AST_PACE_BUF: assert property (
        s_wr_pace |=> pace_buffer_enable_o == $past(wb_dat_i[0]))
        else $error("pace buffer enable not written");

    AST_SENSE_EVENT: assert property (
        |(st_r.loff_s2 & ~st_r.loff_prev & st_r.sense_en)
            |=> |st_r.int_st)
        else $error("sensed electrode-off did not set status");

    AST_IRQ: assert property (
        irq_o == |(st_r.int_st & st_r.int_mask))
        else $error("interrupt level does not match status and mask");

    // ========================================
    // mode, sense, pin, interrupt, bus ack, pace reset and status assertions
    sequence s_wr_resp;
        wr && idx == `LGP_IDX_RESP;
    endsequence

    sequence s_wr_sense;
        wr && idx == `LGP_IDX_SENSE;
    endsequence

    sequence s_wr_gpio_all_out;
        wr && idx == `LGP_IDX_GPIO && st_r.gpio_dir == 4'h0 && !st_r.resp_mode[0];
    endsequence

    sequence s_rd_gpio_lost;
        rd && idx == `LGP_IDX_GPIO && st_r.resp_mode[0];
    endsequence

    sequence s_rd_int_quiet;
        rd && idx == `LGP_IDX_INT_STAT && !(|ev_set);
    endsequence

    property p_int_clear;
        s_rd_int_quiet |=> st_r.int_st == 8'h00 && !irq_o;
    endproperty

    property p_gpio_data_out;
        s_wr_gpio_all_out |=>
            gpio_out_o == ($past(wb_dat_i[7:4]) & ~$past(wb_dat_i[3:0]));
    endproperty

    AST_RESP_MODE: assert property (
        s_wr_resp |=> respiration_mode_o == $past(wb_dat_i[1:0]))
        else $error("respiration mode not written");

    AST_SENSE_WRITE: assert property (
        s_wr_sense |=> negative_sense_enable_o == $past(wb_dat_i[7:0]))
        else $error("sense enable not written");

    AST_GPIO_DATA_OUT: assert property (p_gpio_data_out)
        else $error("data write did not set output pin drive");

    AST_GPIO_READ_LOSS: assert property (
        s_rd_gpio_lost |=> wb_dat_o[7:5] == 3'h0)
        else $error("unavailable pins read nonzero");

    AST_GPIO_OUT_OE: assert property (
        (gpio_out_o & ~gpio_oe_o) == 4'h0)
        else $error("drive value on a pin that is not driven");

    AST_INT_CLEAR: assert property (p_int_clear)
        else $error("status read did not clear events");

    AST_ACK_ONLY_REQ: assert property (
        wb_ack_o |-> $past(hit))
        else $error("ack without a request");

    AST_PACE_RESET: assert property (
        $fell(rst_i) |-> pace_test_output_one_sel_o == 4'h1
            && pace_test_output_two_sel_o == 4'h1
            && !pace_buffer_enable_o)
        else $error("pace routing not at reset value");

    AST_STATN_RESET: assert property (
        $fell(rst_i) |-> st_r.loff_s2 == `LGP_STATN_RST && !irq_o)
        else $error("status not at reset value");

    AST_STATN_SYNC: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
            |-> st_r.loff_s2 == $past(chan_neg_electrode_off_i, 2))
        else $error("status does not follow synchronised comparators");

endmodule

// [bench/lgp_pin_model.sv]
`timescale 1ns/100ps
// ========================================
// external pins: a driven pin shows the drive, else the outside level
module lgp_pin_model (
    // pad side of the block
    input  wire logic [3:0] drive_i,
    input  wire logic [3:0] oe_i,
    // level applied from outside
    input  wire logic [3:0] ext_i,
    // level seen on the pins
    output logic      [3:0] level_o
);
    assign level_o = (drive_i & oe_i) | (ext_i & ~oe_i);
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
`include "lgp_consts.svh"
module tb;
    // ========================================
    // signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [7:0]  loff  = 8'h00;
    logic [7:0]  sense;
    logic [1:0]  mode;
    logic [3:0]  ext   = 4'h0;
    logic [3:0]  pin;
    logic [3:0]  gout;
    logic [3:0]  goe;
    logic [3:0]  one;
    logic [3:0]  two;
    logic        pbuf;
    logic        irq;
    int          err_total  = 0;
    int          num_checks = 0;

    always #20 clk_i = ~clk_i;

    lgp_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .chan_neg_electrode_off_i(loff), .negative_sense_enable_o(sense),
        .respiration_mode_o(mode), .gpio_in_i(pin), .gpio_out_o(gout), .gpio_oe_o(goe),
        .pace_test_output_one_sel_o(one), .pace_test_output_two_sel_o(two),
        .pace_buffer_enable_o(pbuf), .irq_o(irq));

    lgp_pin_model pins (.drive_i(gout), .oe_i(goe), .ext_i(ext), .level_o(pin));

    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                      input logic [3:0] sl, output logic [7:0] rd);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, wd};
        sel  <= sl;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) chk(32'h0, 32'h1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, idx, d, 4'h1, x);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        wb(1'b0, idx, 8'h00, 4'h1, x);
        chk({24'h0, x}, {24'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ========================================
    // scenarios
    task automatic t_reset;
        tick(1);
        chk({goe, gout, one, two}, 32'h0000_0011);
        chk({pbuf, irq}, 32'h0);
        rdc(`LGP_IDX_STATN, 8'h00);
        rdc(`LGP_IDX_GPIO, 8'h0f);
        rdc(`LGP_IDX_PACE, 8'h00);
        rdc(6'h30, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_status;
        loff <= 8'ha5;
        tick(4);
        rdc(`LGP_IDX_STATN, 8'ha5);
        wr(`LGP_IDX_STATN, 8'h5a);
        rdc(`LGP_IDX_STATN, 8'ha5);
        $display("status test done");
    endtask

    task automatic t_gpio;
        ext <= 4'hc;
        wr(`LGP_IDX_GPIO, 8'ha0);
        tick(1);
        chk({goe, gout}, 32'hf0);
        tick(4);
        rdc(`LGP_IDX_GPIO, 8'h00);
        wr(`LGP_IDX_GPIO, 8'ha0);
        tick(5);
        rdc(`LGP_IDX_GPIO, 8'ha0);
        wr(`LGP_IDX_GPIO, 8'h5c);
        tick(1);
        chk({goe, gout}, 32'h31);
        tick(4);
        rdc(`LGP_IDX_GPIO, 8'hdc);
        $display("gpio test done");
    endtask

    task automatic t_modes;
        wr(`LGP_IDX_GPIO, 8'hf0);
        wr(`LGP_IDX_GPIO, 8'hf0);
        ext <= 4'hf;
        for (int m = 0; m < 4; m++) begin
            wr(`LGP_IDX_RESP, 8'(m));
            tick(5);
            chk({30'h0, mode}, m);
            chk({28'h0, goe}, m[0] ? 32'h1 : 32'hf);
            rdc(`LGP_IDX_GPIO, m[0] ? 8'h10 : 8'hf0);
        end
        wr(`LGP_IDX_RESP, 8'h00);
        $display("mode test done");
    endtask

    task automatic t_pace;
        for (int i = 0; i < 32; i++) begin
            wr(`LGP_IDX_PACE, 8'(i));
            tick(1);
            chk({28'h0, one}, 32'h1 << i[4:3]);
            chk({28'h0, two}, 32'h1 << i[2:1]);
            chk({31'h0, pbuf}, i[0]);
            rdc(`LGP_IDX_PACE, 8'(i));
        end
        $display("pace test done");
    endtask

    task automatic t_irq;
        logic [7:0] x;
        loff <= 8'h00;
        wr(`LGP_IDX_SENSE, 8'h01);
        wr(`LGP_IDX_INT_MASK, 8'h01);
        wb(1'b1, `LGP_IDX_INT_MASK, 8'hff, 4'h0, x);
        rdc(`LGP_IDX_INT_MASK, 8'h01);
        rdc(`LGP_IDX_INT_STAT, 8'h00);
        chk({24'h0, sense}, 32'h01);
        loff <= 8'h03;
        tick(6);
        chk({31'h0, irq}, 32'h1);
        rdc(`LGP_IDX_INT_STAT, 8'h01);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        loff <= 8'h00;
        wr(`LGP_IDX_INT_MASK, 8'h00);
        tick(4);
        loff <= 8'h01;
        tick(6);
        chk({31'h0, irq}, 32'h0);
        rdc(`LGP_IDX_INT_STAT, 8'h01);
        $display("interrupt test done");
    endtask

    // ========================================
    // run control
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        tick(8);
        rst_i <= 1'b0;
        t_reset;
        t_status;
        t_gpio;
        t_modes;
        t_pace;
        t_irq;
        stop_test;
    end

    initial begin
        tick(20000);
        err_total++;
        stop_test;
    end
endmodule
